/* File: rtl/int_pin_flag.sv */
// external interrupt pin: level view and sticky rising-edge request flag
`timescale 1ns/1ns
module int_pin_flag (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic intPin,
    input  wire logic clearReq,
    output logic      intLevel,
    output logic      irqFlag
);
    logic prevLevel;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevLevel <= 1'b0;
            intLevel  <= 1'b0;
        end else begin
            prevLevel <= intPin;
            intLevel  <= intPin;
        end
    end

    // a new edge wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqFlag <= port_io_pkg::IRQ_RESET;
        end else if (intPin && !prevLevel) begin
            irqFlag <= 1'b1;
        end else if (clearReq) begin
            irqFlag <= 1'b0;
        end
    end
endmodule : int_pin_flag

/* File: rtl/port_io_control.sv */
// general-purpose port control: grouped ports, bitwise port, alternate functions, interrupt pin
// Functional notes
// R1: grouped direction bits 0..3 select ports 0A, 0B, 0C, 1A; 1 is output.
// R2: reset puts every port in input, all direction and select bits zero.
// R3: port data at 70H-73H bank 0 and 70H bank 1.
// R4: standby: port 0A requests wake-up when any pin is low.
// R5: standby: port 0B requests wake-up when any pin is high.
// R6: ports 0B and 0C in output mode are open-drain.
// R7: port 0D has a direction bit per pin.
// R8: select bit 2 gives port 0D pin 0 to the LED output.
// R9: select bit 1 gives port 0D pin 1 to the timer output.
// R10: select bit 0 gives port 1A to serial; otherwise 3-bit grouped port.
// R11: select bit 3 reads zero and ignores writes.
// R12: alternate-function 0D pins read and write their latch in any direction.
// R13: serial-owned port 1A reads live pins; writes are ignored.
// R14: switching to output puts the latch on the pins at once.
// R15: rising edge on interrupt pin sets request flag 3DH bit 1.
// R16: flag 0FH bit 0 shows the interrupt pin level.
// R17: LED output follows the carrier enable flag.
// R18: port read gives pin levels for inputs, latch for outputs.
`timescale 1ns/1ns
module port_io_control (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // register file access
    input  wire logic [6:0] rfAddr,
    input  wire logic       rfWrite,
    input  wire logic [3:0] rfWrData,
    output logic      [3:0] rfRdData,
    // data memory access to the port registers
    input  wire logic       dmBank,
    input  wire logic [6:0] dmAddr,
    input  wire logic       dmWrite,
    input  wire logic [3:0] dmWrData,
    output logic      [3:0] dmRdData,
    // system status and peripherals
    input  wire logic       standby,
    input  wire logic       carrierEnable,
    input  wire logic       timerOut,
    input  wire logic [2:0] serialPinOut,
    input  wire logic [2:0] serialPinOe,
    output logic      [2:0] serialPinIn,
    output logic            wakeRequestA,
    output logic            wakeRequestB,
    output logic            irqIntFlag,
    // pins
    input  wire logic [3:0] portAIn,
    output logic      [3:0] portAOut,
    output logic      [3:0] portAOe,
    input  wire logic [3:0] portBIn,
    output logic      [3:0] portBOut,
    output logic      [3:0] portBOe,
    input  wire logic [3:0] portCIn,
    output logic      [3:0] portCOut,
    output logic      [3:0] portCOe,
    input  wire logic [3:0] portDIn,
    output logic      [3:0] portDOut,
    output logic      [3:0] portDOe,
    input  wire logic [2:0] portSerialIn,
    output logic      [2:0] portSerialOut,
    output logic      [2:0] portSerialOe,
    input  wire logic       intPin
);
    logic [3:0] groupDir;
    logic [3:0] bitwisePortPinDir;
    logic [2:0] funcSelect;
    logic       serialPinsSelect;
    logic       timerOutSelect;
    logic       ledOutSelect;
    logic       intLevel;
    logic       irqClear;

    logic       wrPortA;
    logic       wrPortB;
    logic       wrPortC;
    logic       wrPortD;
    logic       wrPortSerial;

    logic [3:0] portADataRd;
    logic [3:0] portBDataRd;
    logic [3:0] portCDataRd;
    logic [3:0] portDDataRd;
    logic [2:0] serialPortDataRd;
    logic [3:0] portDLatch;
    logic [3:0] portDLatchOut;
    logic [3:0] portDLatchOe;
    logic [2:0] serialLatchOut;
    logic [2:0] serialLatchOe;
    logic [3:0] portDAltMask;
    logic [3:0] next_rfRdData;
    logic [3:0] next_dmRdData;

    assign serialPinsSelect = funcSelect[port_io_pkg::SERIAL_PINS_SELECT_BIT];
    assign timerOutSelect   = funcSelect[port_io_pkg::TIMER_OUT_SELECT_BIT];
    assign ledOutSelect     = funcSelect[port_io_pkg::LED_OUT_SELECT_BIT];

    // grouped direction register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            groupDir <= port_io_pkg::GROUP_DIR_RESET;                    // [R2]
        end else if (rfWrite && rfAddr == port_io_pkg::RF_GROUP_DIR) begin
            groupDir <= rfWrData;                                        // [R1]
        end
    end

    // per-pin direction register of port 0D
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bitwisePortPinDir <= port_io_pkg::BIT_DIR_RESET;             // [R2]
        end else if (rfWrite && rfAddr == port_io_pkg::RF_BIT_DIR) begin
            bitwisePortPinDir <= rfWrData;                               // [R7]
        end
    end

    // function select register; top bit is not stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            funcSelect <= port_io_pkg::FUNC_SELECT_RESET[2:0];           // [R2]
        end else if (rfWrite && rfAddr == port_io_pkg::RF_FUNC_SELECT) begin
            funcSelect <= rfWrData[2:0];                                 // [R11]
        end
    end

    // writing 0 to the request bit clears it
    assign irqClear = rfWrite && rfAddr == port_io_pkg::RF_IRQ_INT && !rfWrData[port_io_pkg::IRQ_INT_BIT];

    int_pin_flag u_int_pin_flag (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .intPin   (intPin),
        .clearReq (irqClear),
        .intLevel (intLevel),
        .irqFlag  (irqIntFlag)                                           // [R15]
    );

    // register file read-back, one cycle after the address
    always_comb begin
        next_rfRdData = 4'h0;
        unique case (rfAddr)
            port_io_pkg::RF_GROUP_DIR:   next_rfRdData = groupDir;
            port_io_pkg::RF_BIT_DIR:     next_rfRdData = bitwisePortPinDir;
            port_io_pkg::RF_FUNC_SELECT: next_rfRdData = {1'b0, funcSelect};              // [R11]
            port_io_pkg::RF_INT_LEVEL:   next_rfRdData[port_io_pkg::INT_LEVEL_BIT] = intLevel; // [R16]
            port_io_pkg::RF_IRQ_INT:     next_rfRdData[port_io_pkg::IRQ_INT_BIT] = irqIntFlag;
            default:                     next_rfRdData = 4'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rfRdData <= 4'h0;
        end else begin
            rfRdData <= next_rfRdData;
        end
    end

    // data memory decode of port registers
    always_comb begin
        wrPortA      = dmWrite && dmBank == port_io_pkg::BANK_0 && dmAddr == port_io_pkg::DM_PORT_A; // [R3]
        wrPortB      = dmWrite && dmBank == port_io_pkg::BANK_0 && dmAddr == port_io_pkg::DM_PORT_B;
        wrPortC      = dmWrite && dmBank == port_io_pkg::BANK_0 && dmAddr == port_io_pkg::DM_PORT_C;
        wrPortD      = dmWrite && dmBank == port_io_pkg::BANK_0 && dmAddr == port_io_pkg::DM_PORT_D;
        wrPortSerial = dmWrite && dmBank == port_io_pkg::BANK_1 && dmAddr == port_io_pkg::DM_PORT_SERIAL
                       && !serialPinsSelect;                                                 // [R13]
    end

    port_latch_group #(.W(4), .OPEN_DRAIN(1'b0)) u_port_a (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .wrEn       (wrPortA),
        .wrData     (dmWrData),
        .dirBits    ({4{groupDir[port_io_pkg::GRP_A_DIR_BIT]}}),       // [R1]
        .forceLatch (4'h0),
        .forcePin   (4'h0),
        .pinIn      (portAIn),
        .latch      (),
        .rdData     (portADataRd),                                     // [R18]
        .pinOut     (portAOut),
        .pinOe      (portAOe)                                          // [R14]
    );

    port_latch_group #(.W(4), .OPEN_DRAIN(1'b1)) u_port_b (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .wrEn       (wrPortB),
        .wrData     (dmWrData),
        .dirBits    ({4{groupDir[port_io_pkg::GRP_B_DIR_BIT]}}),
        .forceLatch (4'h0),
        .forcePin   (4'h0),
        .pinIn      (portBIn),
        .latch      (),
        .rdData     (portBDataRd),
        .pinOut     (portBOut),
        .pinOe      (portBOe)                                          // [R6]
    );

    port_latch_group #(.W(4), .OPEN_DRAIN(1'b1)) u_port_c (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .wrEn       (wrPortC),
        .wrData     (dmWrData),
        .dirBits    ({4{groupDir[port_io_pkg::GRP_C_DIR_BIT]}}),
        .forceLatch (4'h0),
        .forcePin   (4'h0),
        .pinIn      (portCIn),
        .latch      (),
        .rdData     (portCDataRd),
        .pinOut     (portCOut),
        .pinOe      (portCOe)                                          // [R6]
    );

    // alternate-function pins of port 0D read back their latch
    always_comb begin
        portDAltMask = 4'h0;
        portDAltMask[port_io_pkg::LED_PIN]   = ledOutSelect;           // [R12]
        portDAltMask[port_io_pkg::TIMER_PIN] = timerOutSelect;         // [R12]
    end

    port_latch_group #(.W(4), .OPEN_DRAIN(1'b0)) u_port_d (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .wrEn       (wrPortD),
        .wrData     (dmWrData),
        .dirBits    (bitwisePortPinDir),                               // [R7]
        .forceLatch (portDAltMask),
        .forcePin   (4'h0),
        .pinIn      (portDIn),
        .latch      (portDLatch),
        .rdData     (portDDataRd),
        .pinOut     (portDLatchOut),
        .pinOe      (portDLatchOe)
    );

    // port 0D pin drive with LED and timer takeover
    always_comb begin
        portDOut = portDLatchOut;
        portDOe  = portDLatchOe;
        if (ledOutSelect) begin
            portDOut[port_io_pkg::LED_PIN] = carrierEnable;            // [R8] [R17]
            portDOe[port_io_pkg::LED_PIN]  = 1'b1;
        end
        if (timerOutSelect) begin
            portDOut[port_io_pkg::TIMER_PIN] = timerOut;               // [R9]
            portDOe[port_io_pkg::TIMER_PIN]  = 1'b1;
        end
    end

    port_latch_group #(.W(3), .OPEN_DRAIN(1'b0)) u_port_serial (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .wrEn       (wrPortSerial),
        .wrData     (dmWrData[2:0]),
        .dirBits    ({3{groupDir[port_io_pkg::GRP_SERIAL_PORT_DIR_BIT]}}), // [R10]
        .forceLatch (3'h0),
        .forcePin   ({3{serialPinsSelect}}),                           // [R13]
        .pinIn      (portSerialIn),
        .latch      (),
        .rdData     (serialPortDataRd),
        .pinOut     (serialLatchOut),
        .pinOe      (serialLatchOe)
    );

    // port 1A pins handed to the serial interface
    always_comb begin
        if (serialPinsSelect) begin
            portSerialOut = serialPinOut;                              // [R10]
            portSerialOe  = serialPinOe;
        end else begin
            portSerialOut = serialLatchOut;
            portSerialOe  = serialLatchOe;
        end
    end

    assign serialPinIn = portSerialIn;

    // port data read-back, one cycle after the address
    always_comb begin
        next_dmRdData = 4'h0;
        if (dmBank == port_io_pkg::BANK_0) begin
            unique case (dmAddr)
                port_io_pkg::DM_PORT_A: next_dmRdData = portADataRd;  // [R3]
                port_io_pkg::DM_PORT_B: next_dmRdData = portBDataRd;
                port_io_pkg::DM_PORT_C: next_dmRdData = portCDataRd;
                port_io_pkg::DM_PORT_D: next_dmRdData = portDDataRd;
                default:                next_dmRdData = 4'h0;
            endcase
        end else if (dmAddr == port_io_pkg::DM_PORT_SERIAL) begin
            next_dmRdData = {1'b0, serialPortDataRd};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dmRdData <= 4'h0;
        end else begin
            dmRdData <= next_dmRdData;
        end
    end

    // standby wake-up requests
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wakeRequestA <= 1'b0;
            wakeRequestB <= 1'b0;
        end else begin
            wakeRequestA <= standby && !(&portAIn);                    // [R4]
            wakeRequestB <= standby && (|portBIn);                     // [R5]
        end
    end
endmodule : port_io_control

/* File: rtl/port_io_pkg.sv */
// constants for the port control block: register offsets, field positions, reset values
package port_io_pkg;
    // register file offsets (7-bit register file address)
    localparam logic [6:0] RF_INT_LEVEL   = 7'h0f;
    localparam logic [6:0] RF_FUNC_SELECT = 7'h23;
    localparam logic [6:0] RF_BIT_DIR     = 7'h36;
    localparam logic [6:0] RF_GROUP_DIR   = 7'h37;
    localparam logic [6:0] RF_IRQ_INT     = 7'h3d;

    // data memory locations of the port data registers
    localparam logic       BANK_0         = 1'h0;
    localparam logic       BANK_1         = 1'h1;
    localparam logic [6:0] DM_PORT_A      = 7'h70;
    localparam logic [6:0] DM_PORT_B      = 7'h71;
    localparam logic [6:0] DM_PORT_C      = 7'h72;
    localparam logic [6:0] DM_PORT_D      = 7'h73;
    localparam logic [6:0] DM_PORT_SERIAL = 7'h70;

    // field positions in the grouped direction register
    localparam int GRP_A_DIR_BIT           = 0;
    localparam int GRP_B_DIR_BIT           = 1;
    localparam int GRP_C_DIR_BIT           = 2;
    localparam int GRP_SERIAL_PORT_DIR_BIT = 3;

    // field positions in the function select register
    localparam int SERIAL_PINS_SELECT_BIT = 0;
    localparam int TIMER_OUT_SELECT_BIT   = 1;
    localparam int LED_OUT_SELECT_BIT     = 2;
    localparam int FUNC_RESERVED_BIT      = 3;

    // field positions of the interrupt flags
    localparam int INT_LEVEL_BIT = 0;
    localparam int IRQ_INT_BIT   = 1;

    // port 0D pins taken by alternate functions
    localparam int LED_PIN   = 0;
    localparam int TIMER_PIN = 1;

    // reset values
    localparam logic [3:0] FUNC_SELECT_RESET = 4'h0;
    localparam logic [3:0] GROUP_DIR_RESET   = 4'h0;
    localparam logic [3:0] BIT_DIR_RESET     = 4'h0;
    localparam logic [3:0] LATCH_RESET       = 4'h0;
    localparam logic       IRQ_RESET         = 1'h0;
endpackage : port_io_pkg

/* File: rtl/port_latch_group.sv */
// one port: output latch, direction-aware pin drive and read-back selection
`timescale 1ns/1ns
module port_latch_group #(
    parameter int W          = 4,
    parameter bit OPEN_DRAIN = 1'b0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         wrEn,
    input  wire logic [W-1:0] wrData,
    input  wire logic [W-1:0] dirBits,
    input  wire logic [W-1:0] forceLatch,
    input  wire logic [W-1:0] forcePin,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] latch,
    output logic      [W-1:0] rdData,
    output logic      [W-1:0] pinOut,
    output logic      [W-1:0] pinOe
);
    generate
        if (W < 1 || W > 4) begin : g_bad_width
            $error("port_latch_group: width must be 1 to 4");
        end
    endgenerate

    // output latch keeps its value in any direction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch <= W'(port_io_pkg::LATCH_RESET);
        end else if (wrEn) begin
            latch <= wrData;
        end
    end

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (forcePin[i]) begin
                rdData[i] = pinIn[i];
            end else if (forceLatch[i] || dirBits[i]) begin
                rdData[i] = latch[i];
            end else begin
                rdData[i] = pinIn[i];
            end
        end
    end

    // latch reaches the pins as soon as direction turns to output
    always_comb begin
        if (OPEN_DRAIN) begin
            pinOut = '0;
            pinOe  = dirBits & ~latch;
        end else begin
            pinOut = latch;
            pinOe  = dirBits;
        end
    end
endmodule : port_latch_group

/* File: tb/pin_net.sv */
// board side of one port: external drivers and pull-ups on each pin
`timescale 1ns/1ns
module pin_net #(
    parameter int W = 4
) (
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] extVal,
    input  wire logic [W-1:0] extEn,
    output logic      [W-1:0] pinIn
);
    // a released pin reads the external driver, else the board pull-up
    assign pinIn = (oe & out) | (~oe & extEn & extVal) | (~oe & ~extEn);
endmodule : pin_net

/* File: tb/port_io_control_checker.sv */
// assertion checker for the port control block, bound to its ports
`timescale 1ns/1ns
module port_io_control_checker (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [6:0] rfAddr,
    input wire logic       rfWrite,
    input wire logic [3:0] rfWrData,
    input wire logic       dmBank,
    input wire logic [6:0] dmAddr,
    input wire logic       dmWrite,
    input wire logic [3:0] dmWrData,
    input wire logic       standby,
    input wire logic       carrierEnable,
    input wire logic       timerOut,
    input wire logic [2:0] serialPinOe,
    input wire logic       wakeRequestA,
    input wire logic       wakeRequestB,
    input wire logic       irqIntFlag,
    input wire logic [3:0] portAIn,
    input wire logic [3:0] portAOut,
    input wire logic [3:0] portAOe,
    input wire logic [3:0] portBIn,
    input wire logic [3:0] portBOut,
    input wire logic [3:0] portCOut,
    input wire logic [3:0] portDOut,
    input wire logic [3:0] portDOe,
    input wire logic [2:0] portSerialOe,
    input wire logic       intPin
);
    logic [3:0] grpDir;
    logic [3:0] bitDir;
    logic [2:0] funcSel;
    logic [3:0] latchA;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // shadow of the control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            grpDir  <= 4'h0;
            bitDir  <= 4'h0;
            funcSel <= 3'h0;
        end else if (rfWrite) begin
            if (rfAddr == port_io_pkg::RF_GROUP_DIR) grpDir <= rfWrData;
            if (rfAddr == port_io_pkg::RF_BIT_DIR) bitDir <= rfWrData;
            if (rfAddr == port_io_pkg::RF_FUNC_SELECT) funcSel <= rfWrData[2:0];
        end
    end

    // shadow of the port 0A latch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latchA <= 4'h0;
        end else if (dmWrite && dmBank == port_io_pkg::BANK_0 && dmAddr == port_io_pkg::DM_PORT_A) begin
            latchA <= dmWrData;
        end
    end

    a_grp_a_dir: assert property (portAOe == {4{grpDir[0]}}) else $error("port 0A drive differs from direction");
    a_serial_dir: assert property (funcSel[0] ? portSerialOe == serialPinOe : portSerialOe == {3{grpDir[3]}})
        else $error("port 1A drive owner wrong");
    a_latch_drive: assert property (|portAOe |-> portAOut == latchA) else $error("port 0A pins not latch");
    a_open_drain: assert property (portBOut == 4'h0 && portCOut == 4'h0) else $error("open drain drives high");
    a_bit_dir: assert property (portDOe[3:2] == bitDir[3:2]) else $error("port 0D pin direction wrong");
    a_led_follow: assert property (funcSel[2] |-> portDOut[0] == carrierEnable) else $error("led pin wrong");
    a_timer_route: assert property (funcSel[1] |-> portDOut[1] == timerOut) else $error("timer pin wrong");
    a_wake_a: assert property (standby && portAIn != 4'hF |=> wakeRequestA) else $error("no wake from 0A");
    a_wake_b: assert property (standby && portBIn != 4'h0 |=> wakeRequestB) else $error("no wake from 0B");
    a_wake_idle: assert property (!standby |=> !wakeRequestA && !wakeRequestB) else $error("wake while awake");
    a_irq_edge: assert property ($rose(intPin) |-> ##[0:2] irqIntFlag) else $error("edge did not set flag");

    c_irq: cover property ($rose(irqIntFlag));
    c_led: cover property (funcSel[2] && carrierEnable);
    c_wake: cover property (wakeRequestB);
endmodule : port_io_control_checker

bind port_io_control port_io_control_checker u_chk (
    .clk(clk), .sys_rst(sys_rst), .rfAddr(rfAddr), .rfWrite(rfWrite), .rfWrData(rfWrData),
    .dmBank(dmBank), .dmAddr(dmAddr), .dmWrite(dmWrite), .dmWrData(dmWrData), .standby(standby),
    .carrierEnable(carrierEnable), .timerOut(timerOut), .serialPinOe(serialPinOe),
    .wakeRequestA(wakeRequestA), .wakeRequestB(wakeRequestB), .irqIntFlag(irqIntFlag),
    .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut),
    .portCOut(portCOut), .portDOut(portDOut), .portDOe(portDOe), .portSerialOe(portSerialOe), .intPin(intPin)
);

/* File: tb/port_io_control_test.sv */
// self-checking testbench for the port control block
`timescale 1ns/1ns
module port_io_control_test;
    logic       clk, sys_rst, rfWrite, dmBank, dmWrite, standby, carrierEnable, timerOut, intPin, extOn;
    logic [6:0] rfAddr, dmAddr;
    logic [3:0] rfWrData, dmWrData, rfRdData, dmRdData;
    logic [3:0] aIn, aOut, aOe, bIn, bOut, bOe, cIn, cOut, cOe, dIn, dOut, dOe, aExt, bExt, cExt, dExt;
    logic [2:0] serialPinOut, serialPinOe, serialPinIn, sIn, sOut, sOe, sExt;
    logic       wakeRequestA, wakeRequestB, irqIntFlag;
    int         err_total, samples_checked, cycles;

    port_io_control dut (
        .clk(clk), .sys_rst(sys_rst), .rfAddr(rfAddr), .rfWrite(rfWrite), .rfWrData(rfWrData),
        .rfRdData(rfRdData), .dmBank(dmBank), .dmAddr(dmAddr), .dmWrite(dmWrite), .dmWrData(dmWrData),
        .dmRdData(dmRdData), .standby(standby), .carrierEnable(carrierEnable), .timerOut(timerOut),
        .serialPinOut(serialPinOut), .serialPinOe(serialPinOe), .serialPinIn(serialPinIn),
        .wakeRequestA(wakeRequestA), .wakeRequestB(wakeRequestB), .irqIntFlag(irqIntFlag),
        .portAIn(aIn), .portAOut(aOut), .portAOe(aOe), .portBIn(bIn), .portBOut(bOut), .portBOe(bOe),
        .portCIn(cIn), .portCOut(cOut), .portCOe(cOe), .portDIn(dIn), .portDOut(dOut), .portDOe(dOe),
        .portSerialIn(sIn), .portSerialOut(sOut), .portSerialOe(sOe), .intPin(intPin)
    );
    pin_net #(.W(4)) pa (.out(aOut), .oe(aOe), .extVal(aExt), .extEn({4{extOn}}), .pinIn(aIn));
    pin_net #(.W(4)) pb (.out(bOut), .oe(bOe), .extVal(bExt), .extEn({4{extOn}}), .pinIn(bIn));
    pin_net #(.W(4)) pc (.out(cOut), .oe(cOe), .extVal(cExt), .extEn({4{extOn}}), .pinIn(cIn));
    pin_net #(.W(4)) pd (.out(dOut), .oe(dOe), .extVal(dExt), .extEn({4{extOn}}), .pinIn(dIn));
    pin_net #(.W(3)) ps (.out(sOut), .oe(sOe), .extVal(sExt), .extEn({3{extOn}}), .pinIn(sIn));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    task automatic rf_wr(input logic [6:0] a, input logic [3:0] d);
        @(posedge clk);
        rfAddr   <= a;
        rfWrData <= d;
        rfWrite  <= 1'b1;
        @(posedge clk);
        rfWrite <= 1'b0;
        #1;
    endtask : rf_wr

    task automatic rf_rd(input logic [6:0] a, input logic [3:0] e);
        @(posedge clk);
        rfAddr <= a;
        @(posedge clk);
        #1;
        chk($sformatf("register %h", a), e, rfRdData);
    endtask : rf_rd

    task automatic dm_wr(input logic b, input logic [6:0] a, input logic [3:0] d);
        @(posedge clk);
        dmBank   <= b;
        dmAddr   <= a;
        dmWrData <= d;
        dmWrite  <= 1'b1;
        @(posedge clk);
        dmWrite <= 1'b0;
        #1;
    endtask : dm_wr

    task automatic dm_rd(input logic b, input logic [6:0] a, input logic [3:0] e);
        @(posedge clk);
        dmBank <= b;
        dmAddr <= a;
        @(posedge clk);
        #1;
        chk($sformatf("port %h/%h", b, a), e, dmRdData);
    endtask : dm_rd

    task automatic done(input string nm);
        $display("test %s done, mismatches so far %0d", nm, err_total);
    endtask : done

    initial begin
        {rfWrite, dmBank, dmWrite, standby, carrierEnable, timerOut, intPin, extOn} = 8'h00;
        {rfAddr, dmAddr} = 14'h0000;
        {rfWrData, dmWrData, aExt, bExt, cExt, dExt} = 24'h00_0000;
        {serialPinOut, serialPinOe, sExt} = 9'h000;
        {err_total, samples_checked, cycles} = 96'h0;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rf_rd(7'h37, 4'h0);
        rf_rd(7'h23, 4'h0);
        rf_rd(7'h36, 4'h0);
        chk("drive enables", 4'h0, aOe | bOe | cOe | dOe);
        rf_rd(7'h10, 4'h0);
        rf_wr(7'h23, 4'hF);
        rf_rd(7'h23, 4'h7);
        rf_wr(7'h23, 4'h0);
        done("reset and select");
        @(posedge clk);
        extOn <= 1'b1;
        aExt  <= 4'h9;
        dm_wr(1'b0, 7'h70, 4'h5);
        dm_rd(1'b0, 7'h70, 4'h9);
        rf_wr(7'h37, 4'h1);
        chk("0A drive", 4'hF, aOe);
        chk("0A pins", 4'h5, aOut);
        dm_rd(1'b0, 7'h70, 4'h5);
        rf_rd(7'h37, 4'h1);
        done("port 0A");
        @(posedge clk);
        extOn <= 1'b0;
        dm_wr(1'b0, 7'h71, 4'h5);
        dm_wr(1'b0, 7'h72, 4'h3);
        rf_wr(7'h37, 4'h7);
        chk("0B pull", 4'hA, bOe);
        chk("0C pull", 4'hC, cOe);
        dm_rd(1'b0, 7'h71, 4'h5);
        done("open drain");
        @(posedge clk);
        extOn <= 1'b1;
        dExt  <= 4'h5;
        dm_wr(1'b0, 7'h73, 4'hA);
        rf_wr(7'h36, 4'h3);
        chk("0D drive", 4'h3, dOe);
        dm_rd(1'b0, 7'h73, 4'h6);
        rf_wr(7'h23, 4'h6);
        @(posedge clk);
        carrierEnable <= 1'b1;
        timerOut      <= 1'b0;
        #1;
        chk("alt pins", 4'h1, {2'b00, dOut[1:0]});
        @(posedge clk);
        carrierEnable <= 1'b0;
        timerOut      <= 1'b1;
        #1;
        chk("alt pins", 4'h2, {2'b00, dOut[1:0]});
        rf_wr(7'h36, 4'h0);
        dm_wr(1'b0, 7'h73, 4'hF);
        dm_rd(1'b0, 7'h73, 4'h7);
        rf_wr(7'h23, 4'h0);
        dm_rd(1'b0, 7'h73, 4'h5);
        done("port 0D");
        rf_wr(7'h37, 4'h8);
        dm_wr(1'b1, 7'h70, 4'h3);
        chk("1A pins", 4'h3, {1'b0, sOut});
        chk("1A drive", 4'h7, {1'b0, sOe});
        rf_wr(7'h23, 4'h1);
        @(posedge clk);
        sExt <= 3'h5;
        serialPinOut <= 3'h5;
        serialPinOe <= 3'h5;
        cExt <= 4'h6;
        dm_wr(1'b1, 7'h70, 4'h6);
        dm_rd(1'b1, 7'h70, 4'h5);
        chk("serial in", 4'h5, {1'b0, serialPinIn});
        chk("1A out", 4'h5, {1'b0, sOut});
        chk("1A oe", 4'h5, {1'b0, sOe});
        dm_rd(1'b0, 7'h72, 4'h6);
        rf_wr(7'h23, 4'h0);
        dm_rd(1'b1, 7'h70, 4'h3);
        done("port 1A");
        @(posedge clk);
        standby <= 1'b1;
        aExt    <= 4'hF;
        bExt    <= 4'h0;
        repeat (2) @(posedge clk);
        #1;
        chk("wake", 4'h0, {2'b00, wakeRequestA, wakeRequestB});
        @(posedge clk);
        aExt <= 4'hE;
        bExt <= 4'h1;
        repeat (2) @(posedge clk);
        #1;
        chk("wake", 4'h3, {2'b00, wakeRequestA, wakeRequestB});
        @(posedge clk);
        standby <= 1'b0;
        done("standby");
        @(posedge clk);
        intPin <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("irq flag", 4'h1, {3'b000, irqIntFlag});
        rf_rd(7'h3D, 4'h2);
        rf_rd(7'h0F, 4'h1);
        @(posedge clk);
        intPin <= 1'b0;
        rf_wr(7'h3D, 4'h0);
        rf_rd(7'h3D, 4'h0);
        rf_rd(7'h0F, 4'h0);
        done("interrupt pin");
        report_and_stop();
    end
endmodule : port_io_control_test
